/* rtl/dcrm_defs.svh */
// register offsets, field positions and codes of the drive common register map
`ifndef DCRM_DEFS_SVH
`define DCRM_DEFS_SVH
`define DCRM_OFS_MODEL 16'h0000
`define DCRM_OFS_CAPACITY 16'h0001
`define DCRM_OFS_VCLASS 16'h0002
`define DCRM_OFS_FWREV 16'h0003
`define DCRM_OFS_WRPERM 16'h0004
`define DCRM_OFS_SPEEDREF 16'h0005
`define DCRM_OFS_CMD 16'h0006
`define DCRM_OFS_RAMPUP 16'h0007
`define DCRM_OFS_RAMPDN 16'h0008
`define DCRM_OFS_CURRENT 16'h0009
`define DCRM_OFS_FREQ 16'h000a
`define DCRM_OFS_VOLT 16'h000b
`define DCRM_OFS_BUSV 16'h000c
`define DCRM_OFS_POWER 16'h000d
`define DCRM_OFS_STATE 16'h000e
`define DCRM_FC_RD_HOLD 8'h03
`define DCRM_FC_RD_INPUT 8'h04
`define DCRM_FC_WR_SINGLE 8'h06
`define DCRM_FC_WR_MULTI 8'h10
`define DCRM_EXC_NONE 8'h00
`define DCRM_EXC_FUNC 8'h01
`define DCRM_EXC_ADDR 8'h02
`define DCRM_EXC_WRDIS 8'h14
`define DCRM_CMD_STOP 0
`define DCRM_CMD_FWD 1
`define DCRM_CMD_REV 2
`define DCRM_CMD_FRST 3
`define DCRM_CMD_ESTOP 4
`define DCRM_CMD_SRC_LO 6
`define DCRM_CMD_FSRC_LO 8
`define DCRM_CMD_NETERR 15
`define DCRM_CMD_WMASK 16'h1fdf
`define DCRM_RST_ZERO 16'h0000
`define DCRM_VCLASS_220 16'h0000
`define DCRM_VCLASS_400 16'h0001
`define DCRM_VCLASS_600 16'h0002
`endif

/* rtl/dcrm_pkg.sv */
// types of the drive common register map
package dcrm_pkg;
  typedef enum logic [1:0] {
    DCRM_SRC_TERMINAL,
    DCRM_SRC_KEYPAD,
    DCRM_SRC_OPTION,
    DCRM_SRC_SERIAL
  } dcrm_src_e;
  typedef logic [15:0] dcrm_word_t;
endpackage

/* rtl/dcrm_regs.sv */
// register bank of the drive common area, served by the serial frame decoder
`include "dcrm_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module dcrm_regs #(
  parameter logic [15:0] MODEL_ID = 16'h0001, // arbitrary value
  parameter logic [15:0] CAPACITY_ID = 16'h0004,
  parameter logic [1:0] VCLASS_SEL = 2'h1,
  parameter logic [15:0] FW_REV = 16'h0100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access strobe from the frame decoder, one word per strobe
  input wire logic acc_req_i,
  input wire logic [7:0] acc_func_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  // answer to the access
  output logic acc_ack_o,
  output logic [15:0] acc_rdata_o,
  output logic [7:0] acc_exc_o,
  // live drive measurements and state, from outside the clock domain
  input wire logic [15:0] motor_current_i,
  input wire logic [15:0] motor_frequency_i,
  input wire logic [15:0] motor_voltage_i,
  input wire logic [15:0] bus_voltage_i,
  input wire logic [15:0] motor_power_i,
  input wire logic [10:0] drive_flags_i,
  input wire logic net_error_i,
  // controls to the drive core
  output logic [15:0] speed_reference_o,
  output logic [15:0] ramp_up_time_o,
  output logic [15:0] ramp_down_time_o,
  output logic stop_req_o,
  output logic fwd_req_o,
  output logic rev_req_o,
  output logic estop_o,
  output logic fault_clear_o,
  output logic [1:0] run_source_o,
  output logic [4:0] freq_source_o
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the measurement inputs
  logic [15:0] meas_s1_ff [5];
  logic [15:0] meas_s2_ff [5];
  logic [15:0] meas_in [5];
  logic [11:0] flg_s1_ff;
  logic [11:0] flg_s2_ff;
  assign meas_in[0] = motor_current_i;
  assign meas_in[1] = motor_frequency_i;
  assign meas_in[2] = motor_voltage_i;
  assign meas_in[3] = bus_voltage_i;
  assign meas_in[4] = motor_power_i;

  // word-wide sync may tear a word mid-change; the core holds values steady
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_meas
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meas_s1_ff[gi] <= `DCRM_RST_ZERO;
          meas_s2_ff[gi] <= `DCRM_RST_ZERO;
        end else begin
          meas_s1_ff[gi] <= meas_in[gi];
          meas_s2_ff[gi] <= meas_s1_ff[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flg_s1_ff <= 12'h000;
      flg_s2_ff <= 12'h000;
    end else begin
      flg_s1_ff <= {net_error_i, drive_flags_i};
      flg_s2_ff <= flg_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  logic [15:0] wr_perm_ff;
  logic [15:0] speed_ref_ff;
  logic [15:0] cmd_ff;
  logic [15:0] ramp_up_ff;
  logic [15:0] ramp_dn_ff;
  logic net_err_ff;
  logic fault_clear_ff;
  logic ack_ff;
  logic [15:0] rdata_ff;
  logic [7:0] exc_ff;

  wire is_read = acc_func_i == `DCRM_FC_RD_HOLD || acc_func_i == `DCRM_FC_RD_INPUT;
  wire is_write = acc_func_i == `DCRM_FC_WR_SINGLE || acc_func_i == `DCRM_FC_WR_MULTI;
  wire addr_ok = acc_addr_i <= `DCRM_OFS_STATE;
  wire addr_rw = acc_addr_i == `DCRM_OFS_WRPERM || acc_addr_i == `DCRM_OFS_SPEEDREF
    || acc_addr_i == `DCRM_OFS_CMD || acc_addr_i == `DCRM_OFS_RAMPUP
    || acc_addr_i == `DCRM_OFS_RAMPDN;
  // the permission register itself stays writable so a locked master can unlock
  wire unlocked = wr_perm_ff != `DCRM_RST_ZERO || acc_addr_i == `DCRM_OFS_WRPERM;
  wire [7:0] nxt_exc = !(is_read || is_write) ? `DCRM_EXC_FUNC :
    !addr_ok ? `DCRM_EXC_ADDR :
    (is_write && (!addr_rw || !unlocked)) ? `DCRM_EXC_WRDIS : `DCRM_EXC_NONE;
  wire wr_go = acc_req_i && is_write && nxt_exc == `DCRM_EXC_NONE;
  wire wr_perm = wr_go && acc_addr_i == `DCRM_OFS_WRPERM;
  wire wr_speed = wr_go && acc_addr_i == `DCRM_OFS_SPEEDREF;
  wire wr_cmd = wr_go && acc_addr_i == `DCRM_OFS_CMD;
  wire wr_rup = wr_go && acc_addr_i == `DCRM_OFS_RAMPUP;
  wire wr_rdn = wr_go && acc_addr_i == `DCRM_OFS_RAMPDN;
  // fault clear fires only on a 0 to 1 step of the reset bit
  wire frst_rise = wr_cmd && acc_wdata_i[`DCRM_CMD_FRST] && !cmd_ff[`DCRM_CMD_FRST];
  // hardware set beats a software clear of the error bit
  wire nxt_net_err = flg_s2_ff[11] ? 1'b1 :
    wr_cmd ? acc_wdata_i[`DCRM_CMD_NETERR] : net_err_ff;
  wire [15:0] cmd_word = {net_err_ff, cmd_ff[14:0]};
  wire [15:0] state_word = {5'h00, flg_s2_ff[10:0]};
  wire [15:0] vclass_word = {14'h0000, VCLASS_SEL};

  logic [15:0] nxt_rdata;
  always_comb begin
    case (acc_addr_i)
      `DCRM_OFS_MODEL: nxt_rdata = MODEL_ID;
      `DCRM_OFS_CAPACITY: nxt_rdata = CAPACITY_ID;
      `DCRM_OFS_VCLASS: nxt_rdata = vclass_word;
      `DCRM_OFS_FWREV: nxt_rdata = FW_REV;
      `DCRM_OFS_WRPERM: nxt_rdata = wr_perm_ff;
      `DCRM_OFS_SPEEDREF: nxt_rdata = speed_ref_ff;
      `DCRM_OFS_CMD: nxt_rdata = cmd_word;
      `DCRM_OFS_RAMPUP: nxt_rdata = ramp_up_ff;
      `DCRM_OFS_RAMPDN: nxt_rdata = ramp_dn_ff;
      `DCRM_OFS_CURRENT: nxt_rdata = meas_s2_ff[0];
      `DCRM_OFS_FREQ: nxt_rdata = meas_s2_ff[1];
      `DCRM_OFS_VOLT: nxt_rdata = meas_s2_ff[2];
      `DCRM_OFS_BUSV: nxt_rdata = meas_s2_ff[3];
      `DCRM_OFS_POWER: nxt_rdata = meas_s2_ff[4];
      `DCRM_OFS_STATE: nxt_rdata = state_word;
      default: nxt_rdata = `DCRM_RST_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_perm_ff <= `DCRM_RST_ZERO;
      speed_ref_ff <= `DCRM_RST_ZERO;
      ramp_up_ff <= `DCRM_RST_ZERO;
      ramp_dn_ff <= `DCRM_RST_ZERO;
      cmd_ff <= `DCRM_RST_ZERO;
      net_err_ff <= 1'b0;
      fault_clear_ff <= 1'b0;
    end else begin
      if (wr_perm) wr_perm_ff <= acc_wdata_i;
      if (wr_speed) speed_ref_ff <= acc_wdata_i;
      if (wr_rup) ramp_up_ff <= acc_wdata_i;
      if (wr_rdn) ramp_dn_ff <= acc_wdata_i;
      // bit 5 and bits 13..14 have no function and store nothing
      if (wr_cmd) cmd_ff <= acc_wdata_i & `DCRM_CMD_WMASK;
      net_err_ff <= nxt_net_err;
      fault_clear_ff <= frst_rise;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= `DCRM_RST_ZERO;
      exc_ff <= `DCRM_EXC_NONE;
    end else begin
      ack_ff <= acc_req_i;
      if (acc_req_i) begin
        rdata_ff <= (is_read && nxt_exc == `DCRM_EXC_NONE) ? nxt_rdata : `DCRM_RST_ZERO;
        exc_ff <= nxt_exc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign acc_ack_o = ack_ff;
  assign acc_rdata_o = rdata_ff;
  assign acc_exc_o = exc_ff;
  assign speed_reference_o = speed_ref_ff;
  assign ramp_up_time_o = ramp_up_ff;
  assign ramp_down_time_o = ramp_dn_ff;
  assign stop_req_o = cmd_ff[`DCRM_CMD_STOP];
  assign fwd_req_o = cmd_ff[`DCRM_CMD_FWD];
  assign rev_req_o = cmd_ff[`DCRM_CMD_REV];
  assign estop_o = cmd_ff[`DCRM_CMD_ESTOP];
  assign fault_clear_o = fault_clear_ff;
  assign run_source_o = cmd_ff[`DCRM_CMD_SRC_LO +: 2];
  assign freq_source_o = cmd_ff[`DCRM_CMD_FSRC_LO +: 5];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  locked_write_a: assert property (
    acc_req_i && is_write && wr_perm_ff == 16'h0000 && acc_addr_i != `DCRM_OFS_WRPERM
      && acc_addr_i <= `DCRM_OFS_STATE |=> acc_ack_o && acc_exc_o == 8'h14)
    else $error("locked write not refused with 0x14");
  locked_hold_a: assert property (
    acc_req_i && is_write && wr_perm_ff == 16'h0000 && acc_addr_i == `DCRM_OFS_SPEEDREF
      |=> $stable(speed_reference_o))
    else $error("locked write changed speed reference");
  fault_edge_a: assert property (
    fault_clear_o |-> $past(wr_cmd) && !$past(cmd_ff[3]) && cmd_ff[3])
    else $error("fault clear without rising edge");
  fault_once_a: assert property (
    fault_clear_o |=> !fault_clear_o)
    else $error("fault clear repeated on steady level");
  cmd_fields_a: assert property (
    wr_cmd ##1 1'b1 |-> {fwd_req_o, rev_req_o, stop_req_o}
      == {$past(acc_wdata_i[1]), $past(acc_wdata_i[2]), $past(acc_wdata_i[0])})
    else $error("run bits not taken from command write");
  estop_src_a: assert property (
    wr_cmd |=> estop_o == $past(acc_wdata_i[4]) && run_source_o == $past(acc_wdata_i[7:6]))
    else $error("emergency stop or source field wrong");
  freq_src_a: assert property (
    wr_cmd |=> freq_source_o == $past(acc_wdata_i[12:8]))
    else $error("frequency source field wrong");
  net_err_a: assert property (
    flg_s2_ff[11] |=> net_err_ff)
    else $error("network error bit not set");
  vclass_rd_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_VCLASS |=> acc_rdata_o == {14'h0, VCLASS_SEL})
    else $error("voltage class read wrong");
  state_rd_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_STATE
      |=> acc_rdata_o[10:0] == $past(flg_s2_ff[10:0]))
    else $error("status word read wrong");
  bad_func_a: assert property (
    acc_req_i && !is_read && !is_write |=> acc_exc_o == 8'h01)
    else $error("illegal function not refused");
  fwrev_rd_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_FWREV
      |=> acc_rdata_o == FW_REV)
    else $error("firmware revision read wrong");
  speed_wr_a: assert property (
    wr_speed |=> speed_reference_o == $past(acc_wdata_i))
    else $error("speed reference not stored");
  ramp_up_a: assert property (
    wr_rup |=> ramp_up_time_o == $past(acc_wdata_i))
    else $error("ramp up time not stored");
  ramp_down_a: assert property (
    wr_rdn |=> ramp_down_time_o == $past(acc_wdata_i))
    else $error("ramp down time not stored");
  ack_pulse_a: assert property (
    acc_req_i |=> acc_ack_o)
    else $error("access not answered");
  ack_idle_a: assert property (
    !acc_req_i |=> !acc_ack_o)
    else $error("answer without access");
  bad_addr_a: assert property (
    acc_req_i && (is_read || is_write) && acc_addr_i > `DCRM_OFS_STATE
      |=> acc_exc_o == `DCRM_EXC_ADDR && acc_rdata_o == `DCRM_RST_ZERO)
    else $error("bad address not refused");
  ro_write_a: assert property (
    acc_req_i && is_write && (acc_addr_i < `DCRM_OFS_WRPERM
      || (acc_addr_i > `DCRM_OFS_RAMPDN && acc_addr_i <= `DCRM_OFS_STATE))
      |=> acc_exc_o == `DCRM_EXC_WRDIS)
    else $error("write to read-only register not refused");
  state_fault_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_STATE
      |=> acc_rdata_o[5:3] == $past(flg_s2_ff[5:3]))
    else $error("fault or ramp status read wrong");
  state_mode_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_STATE
      |=> acc_rdata_o[15:6] == {5'h00, $past(flg_s2_ff[10:6])})
    else $error("mode status read wrong");
  net_err_rd_a: assert property (
    acc_req_i && is_read && acc_addr_i == `DCRM_OFS_CMD
      |=> acc_rdata_o[`DCRM_CMD_NETERR] == $past(net_err_ff))
    else $error("network error bit read wrong");
  wr_rdata_a: assert property (
    acc_req_i && is_write |=> acc_rdata_o == `DCRM_RST_ZERO)
    else $error("write answered with read data");

  // typed view of the source field, only for coverage
  dcrm_pkg::dcrm_src_e run_src;
  assign run_src = dcrm_pkg::dcrm_src_e'(cmd_ff[`DCRM_CMD_SRC_LO +: 2]);
  estop_cv: cover property (wr_cmd ##1 estop_o);
  serial_src_cv: cover property (run_src == dcrm_pkg::DCRM_SRC_SERIAL);
  unlock_cv: cover property (wr_perm ##[1:20] wr_cmd);
  reset_cv: cover property (fault_clear_o);
  locked_cv: cover property (acc_ack_o && acc_exc_o == 8'h14);
endmodule // dcrm_regs

/* tb/dcrm_master.sv */
// register access master model standing in for the frame decoder side
module dcrm_master (
  // clock
  input wire logic clk_i,
  // access strobe and qualifiers
  output logic req_o,
  output logic [7:0] func_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = 1'b0;
    func_o = 8'h00;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // one word per strobe; a multi-word write is a series of calls
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    req_o = 1'b1;
    func_o = f;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    // stale qualifiers must not look valid, so show the inverse
    func_o = ~f;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule // dcrm_master

/* tb/drive_common_register_map_tb_top.sv */
// self-checking bench of the drive common register map
module drive_common_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req, ack, fclr, estop, stp, fwd, rev, net_error = 1'b0, cmd15 = 1'b0;
  logic [7:0] func, exc;
  logic [15:0] addr, wdata, rdata, sref, rup, rdn;
  logic [1:0] rsrc;
  logic [4:0] fsrc;
  logic [15:0] meas [9:14] = '{default: 16'h0000};
  logic [15:0] mem [0:15] = '{0: 16'h0001, 1: 16'h0004, 2: 16'h0001, 3: 16'h0100,
    default: 16'h0000};
  logic [7:0] fl [0:4] = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h05};
  logic [31:0] seed = 32'h2832;
  logic [15:0] a, d;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  dcrm_master dm (.clk_i(clk_i), .req_o(req), .func_o(func), .addr_o(addr), .wdata_o(wdata));
  // model code value is arbitrary
  dcrm_regs #(.MODEL_ID(16'h0001), .CAPACITY_ID(16'h0004), .VCLASS_SEL(2'h1),
    .FW_REV(16'h0100)) dut (.clk_i(clk_i), .rst_i(rst_i), .acc_req_i(req),
    .acc_func_i(func), .acc_addr_i(addr), .acc_wdata_i(wdata), .acc_ack_o(ack),
    .acc_rdata_o(rdata), .acc_exc_o(exc), .motor_current_i(meas[9]),
    .motor_frequency_i(meas[10]), .motor_voltage_i(meas[11]), .bus_voltage_i(meas[12]),
    .motor_power_i(meas[13]), .drive_flags_i(meas[14][10:0]), .net_error_i(net_error),
    .speed_reference_o(sref), .ramp_up_time_o(rup), .ramp_down_time_o(rdn),
    .stop_req_o(stp), .fwd_req_o(fwd), .rev_req_o(rev), .estop_o(estop),
    .fault_clear_o(fclr), .run_source_o(rsrc), .freq_source_o(fsrc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic outs(input logic fc);
    chk(sref, mem[5]);
    chk(rup, mem[7]);
    chk(rdn, mem[8]);
    chk({5'h00, fsrc, rsrc, estop, rev, fwd, stp},
      {5'h00, mem[6][12:6], mem[6][4], mem[6][2:0]});
    chk({15'h0000, fclr}, {15'h0000, fc});
  endtask
  // reference model of one access, then the design's answer is compared
  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    logic wr, fc;
    logic [7:0] ex;
    logic [15:0] rd;
    wr = (f == 8'h06) || (f == 8'h10);
    ex = 8'h00;
    rd = 16'h0000;
    fc = 1'b0;
    if (!(wr || f == 8'h03 || f == 8'h04))
      ex = 8'h01;
    else if (a > 16'h000e)
      ex = 8'h02;
    else if (wr && (a < 16'h0004 || a > 16'h0008 || (a != 16'h0004 && mem[4] == 16'h0000)))
      ex = 8'h14;
    else if (wr && a == 16'h0006) begin
      fc = d[3] && !mem[6][3];
      mem[6] = d & 16'h1fdf;
      cmd15 = net_error;
    end else if (wr)
      mem[a] = d;
    else if (a == 16'h0006)
      rd = mem[6] | {cmd15, 15'h0000};
    else if (a > 16'h0008)
      rd = meas[a];
    else
      rd = mem[a];
    dm.xfer(f, a, d);
    chk({15'h0000, ack}, 16'h0001);
    chk({8'h00, exc}, {8'h00, ex});
    chk(rdata, rd);
    outs(fc);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    outs(1'b0);
    acc(8'h06, 16'h0006, 16'h0002);
    acc(8'h06, 16'h0005, 16'h1234);
    acc(8'h03, 16'h0002, 16'h0000);
    acc(8'h04, 16'h0003, 16'h0000);
    acc(8'h06, 16'h0004, 16'h0001);
    for (int i = 0; i < 32; i++) begin
      acc(8'h10, 16'h0006, {3'h0, 5'(i), 2'(i), 1'b1, 5'(i)});
    end
    net_error = 1'b1;
    repeat (3) @(negedge clk_i);
    cmd15 = 1'b1;
    acc(8'h06, 16'h0006, 16'h0000);
    net_error = 1'b0;
    repeat (3) @(negedge clk_i);
    acc(8'h03, 16'h0006, 16'h0000);
    acc(8'h06, 16'h0006, 16'h0000);
    acc(8'h03, 16'h0006, 16'h0000);
    for (int n = 0; n < 250; n++) begin
      for (int k = 9; k < 15; k++) begin
        meas[k] = (k == 14) ? (rnd() & 16'h07ff) : rnd();
      end
      repeat (3) @(negedge clk_i);
      a = rnd() % 18;
      d = rnd();
      if (a == 16'h0004)
        d = d & 16'h0001;
      if (a == 16'h0006)
        d = d & 16'h7fff;
      acc(fl[rnd() % 5], a, d);
    end
    test_done();
  end
endmodule // drive_common_register_map_tb_top
